// ===== src/twowire_slave_pkg.sv
// shared constants and state type for the two-wire register slave
// assumes sys_clk is much faster than scl, so every scl edge is seen
package twowire_slave_pkg;

  // ---------------------------------------------------------------
  // address byte and memory map
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_FIXED    = 3'b011;  // top three id bits
  localparam logic [3:0] SLAVE_ID_RST  = 4'h6;    // low id bits 0110
  localparam logic [7:0] SLAVE_ID_LOC  = 8'h7D;   // id config byte
  localparam logic [7:0] WR_TOP        = 8'h4F;   // last auto-inc write
  localparam logic [7:0] FUNCTION_COMMAND_BYTE_LOC      = 8'hFE;   // function command
  localparam logic [7:0] READ_PAST     = 8'hFF;   // data past the top
  localparam logic [8:0] PTR_END       = 9'h100;  // one past last byte
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT      = 4'h7;

  // ---------------------------------------------------------------
  // transfer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ACK_ADDR = 3'b010,
    ST_RX       = 3'b011,
    ST_ACK_RX   = 3'b100,
    ST_TX       = 3'b101,
    ST_ACK_TX   = 3'b110
  } slv_state_e;

endpackage

// ===== src/shadow_ram.sv
// shadow ram holding the register space seen over the two-wire port
// assumes one writer; read data is registered, one cycle after address
module shadow_ram #(
  parameter int AW = 8,  // address width
  parameter int DW = 8   // data width
) (
  input  wire logic          sys_clk_i,  // system clock
  input  wire logic          rst_n_i,    // sync reset, active low
  input  wire logic          we_i,       // write strobe
  input  wire logic [AW-1:0] waddr_i,    // write address
  input  wire logic [DW-1:0] wdata_i,    // write data
  input  wire logic [AW-1:0] raddr_i,    // read address
  output logic      [DW-1:0] rdata_o     // registered read data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ---------------------------------------------------------------
  // storage; array is not reset, contents are undefined at power-up
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // read port register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule

// ===== src/twowire_register_access_slave.sv
// slave-only two-wire port giving a master access to the shadow ram
// assumes scl and sda come from pins; both pass two sync flops first
// Function
// - address byte is 011, four programmable id bits, then direction bit.
// - low id bits come from upper nibble of byte 7Dh, reset 0110.
// - direction 0 means master writes, direction 1 means device returns.
// - when idle, wait for start plus matching address, then acknowledge.
// - write is address, pointer byte, data bytes; each byte acknowledged.
// - first data byte lands at pointer; pointer steps after each lsb.
// - auto-increment writes beyond 4Fh are dropped.
// - writes to read-only or reserved locations change nothing.
// - auto-increment onto FEh is ignored; only a direct write counts.
// - short bytes and unacknowledged bytes never reach memory; the code stores each whole byte at its lsb, before the ack.
// - writes touch only the volatile shadow copy, never nonvolatile.
// - read is pointer write, repeated start, address with direction 1.
// - device drives sda from address ack, releases for master acks.
// - read starts with msb at pointer; pointer steps after each lsb.
// - reads beyond FFh return FFh.
// - reserved locations may read as anything.
// - master nack ends a read; device releases sda after that clock.
module twowire_register_access_slave
  import twowire_slave_pkg::*;
#(
  parameter logic [255:0] RO_MAP = '0  // one bit per read-only location
) (
  input  wire logic       sys_clk_i,    // system clock, 10 MHz
  input  wire logic       rst_n_i,      // sync reset, active low
  input  wire logic       scl_i,        // serial clock pin
  input  wire logic       sda_i,        // serial data pin level
  output logic            sda_o,        // serial data drive value
  output logic            sda_oe_o,     // high while pulling sda low
  output logic [3:0]      slave_id_o,   // programmable id bits
  output logic            wr_stb_o,     // one pulse per stored byte
  output logic [7:0]      wr_addr_o,    // location of stored byte
  output logic [7:0]      wr_data_o,    // value of stored byte
  output logic            function_command_byte_stb_o,   // function command written
  output logic [7:0]      function_command_byte_data_o,  // function command value
  output logic            busy_o        // transfer addressed to us
);
  // every check samples on the system clock and sleeps through reset
  default clocking chk_clk @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ---------------------------------------------------------------
  // pin synchronisers and edge finders
  // ---------------------------------------------------------------
  logic       scl_m, scl_s, scl_q;
  logic       sda_m, sda_s, sda_q;
  logic       scl_rise, scl_fall, bus_start, bus_stop;

  // first flop only feeds the second; edges come from the second on
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      {scl_q, scl_s, scl_m} <= '1;  // idle high, no false edge
      {sda_q, sda_s, sda_m} <= '1;
    end else begin
      {scl_q, scl_s, scl_m} <= {scl_s, scl_m, scl_i};
      {sda_q, sda_s, sda_m} <= {sda_s, sda_m, sda_i};
    end
  end

  assign scl_rise  = scl_s && !scl_q;
  assign scl_fall  = !scl_s && scl_q;
  assign bus_start = scl_s && scl_q && sda_q && !sda_s;
  assign bus_stop  = scl_s && scl_q && !sda_q && sda_s;

  // ---------------------------------------------------------------
  // transfer state
  // ---------------------------------------------------------------
  slv_state_e state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic [7:0] tx, next_tx;
  logic [8:0] ptr, next_ptr;
  logic       have_ptr, next_have_ptr;
  logic       first, next_first;
  logic       ovf, next_ovf;
  logic       mack, next_mack;
  logic       drive, next_drive;
  logic [3:0] slave_id, next_slave_id;
  logic       next_wr_stb, next_function_command_byte_stb;
  logic [7:0] next_wr_addr, next_wr_data, next_function_command_byte_data;
  logic       mem_we, wr_ok, match;
  logic [7:0] rx_byte, mem_rdata, rd_byte;

  assign rx_byte = {sh[6:0], sda_s};
  assign match   = (sh[7:1] == {ADDR_FIXED, slave_id});

  // past the top the bus reads all ones; id byte reads the live id
  assign rd_byte = ptr[8] ? READ_PAST
                 : (ptr[7:0] == SLAVE_ID_LOC) ? {slave_id, 4'h0}
                 : mem_rdata;

  // a data byte may land only inside the writable window
  assign wr_ok = !ovf && !ptr[8]
              && (first || ptr[7:0] <= WR_TOP)
              && !RO_MAP[ptr[7:0]]
              && !(ptr[7:0] == FUNCTION_COMMAND_BYTE_LOC && !first);

  // next-state logic for the whole byte engine
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_sh        = sh;
    next_tx        = tx;
    next_ptr       = ptr;
    next_have_ptr  = have_ptr;
    next_first     = first;
    next_ovf       = ovf;
    next_mack      = mack;
    next_drive     = drive;
    next_slave_id  = slave_id;
    next_wr_stb    = 1'b0;
    next_wr_addr   = wr_addr_o;
    next_wr_data   = wr_data_o;
    next_function_command_byte_stb  = 1'b0;
    next_function_command_byte_data = function_command_byte_data_o;
    mem_we         = 1'b0;
    if (bus_stop) begin
      // partial byte is simply forgotten
      next_state = ST_IDLE;
      next_drive = 1'b0;
    end else if (bus_start) begin
      // repeated start keeps the pointer for the read portion
      next_state = ST_ADDR;
      next_cnt   = '0;
      next_drive = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_drive = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            next_sh  = rx_byte;
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == BITS_PER_BYTE) begin
            if (match) begin
              next_state = ST_ACK_ADDR;
              next_drive = 1'b1;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            next_cnt = '0;
            if (sh[0]) begin
              // device keeps sda from here on, msb first
              next_state = ST_TX;
              next_tx    = rd_byte;
              next_drive = !rd_byte[7];
            end else begin
              next_state    = ST_RX;
              next_drive    = 1'b0;
              next_have_ptr = 1'b0;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            next_sh  = rx_byte;
            next_cnt = cnt + 4'h1;
            if (cnt == LAST_BIT) begin
              if (!have_ptr) begin
                next_ptr      = {1'b0, rx_byte};
                next_have_ptr = 1'b1;
                next_first    = 1'b1;
                next_ovf      = 1'b0;
              end else begin
                // only whole bytes get here; shadow copy only
                mem_we       = wr_ok;
                next_wr_stb  = wr_ok;
                next_wr_addr = ptr[7:0];
                next_wr_data = rx_byte;
                if (wr_ok && ptr[7:0] == SLAVE_ID_LOC) begin
                  next_slave_id = rx_byte[7:4];
                end
                if (wr_ok && ptr[7:0] == FUNCTION_COMMAND_BYTE_LOC) begin
                  next_function_command_byte_stb  = 1'b1;
                  next_function_command_byte_data = rx_byte;
                end
                if (ptr[7:0] >= WR_TOP) begin
                  next_ovf = 1'b1;
                end
                next_first = 1'b0;
                next_ptr   = (ptr < PTR_END) ? ptr + 9'h001 : ptr;
              end
            end
          end else if (scl_fall && cnt == BITS_PER_BYTE) begin
            next_state = ST_ACK_RX;
            next_drive = 1'b1;
          end
        end
        ST_ACK_RX: begin
          if (scl_fall) begin
            next_state = ST_RX;
            next_cnt   = '0;
            next_drive = 1'b0;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            next_cnt = cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == BITS_PER_BYTE) begin
              // hand sda to the master for its acknowledge
              next_state = ST_ACK_TX;
              next_drive = 1'b0;
              next_ptr   = (ptr < PTR_END) ? ptr + 9'h001 : ptr;
            end else begin
              next_tx    = {tx[6:0], 1'b0};
              next_drive = !tx[6];
            end
          end
        end
        ST_ACK_TX: begin
          if (scl_rise) begin
            next_mack = !sda_s;
          end else if (scl_fall) begin
            next_cnt = '0;
            if (mack) begin
              next_state = ST_TX;
              next_tx    = rd_byte;
              next_drive = !rd_byte[7];
            end else begin
              // nack: sda stays with the master
              next_state = ST_IDLE;
              next_drive = 1'b0;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_drive = 1'b0;
        end
      endcase
    end
  end

  // registers of the byte engine
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state       <= ST_IDLE;
      cnt         <= '0;
      sh          <= '0;
      tx          <= '0;
      ptr         <= '0;
      have_ptr    <= 1'b0;
      first       <= 1'b0;
      ovf         <= 1'b0;
      mack        <= 1'b0;
      drive       <= 1'b0;
      slave_id    <= SLAVE_ID_RST;
      wr_stb_o    <= 1'b0;
      wr_addr_o   <= '0;
      wr_data_o   <= '0;
      function_command_byte_stb_o  <= 1'b0;
      function_command_byte_data_o <= '0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      sh          <= next_sh;
      tx          <= next_tx;
      ptr         <= next_ptr;
      have_ptr    <= next_have_ptr;
      first       <= next_first;
      ovf         <= next_ovf;
      mack        <= next_mack;
      drive       <= next_drive;
      slave_id    <= next_slave_id;
      wr_stb_o    <= next_wr_stb;
      wr_addr_o   <= next_wr_addr;
      wr_data_o   <= next_wr_data;
      function_command_byte_stb_o  <= next_function_command_byte_stb;
      function_command_byte_data_o <= next_function_command_byte_data;
    end
  end

  // open drain: only ever pull low
  assign sda_o      = 1'b0;
  assign sda_oe_o   = drive;
  assign slave_id_o = slave_id;
  assign busy_o     = (state != ST_IDLE) && (state != ST_ADDR);

  // ---------------------------------------------------------------
  // shadow memory
  // ---------------------------------------------------------------
  shadow_ram #(
    .AW (8),
    .DW (8)
  ) u_ram (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .we_i      (mem_we),
    .waddr_i   (ptr[7:0]),
    .wdata_i   (rx_byte),
    .raddr_i   (ptr[7:0]),
    .rdata_o   (mem_rdata)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  addr_ack_a: assert property (state == ST_ADDR && scl_fall
    && cnt == BITS_PER_BYTE && match && !bus_start && !bus_stop
    |=> state == ST_ACK_ADDR && sda_oe_o) else $error("no address ack");
  addr_bits_a: assert property (state == ST_ACK_ADDR |-> sda_oe_o
    && sh[7:1] == {ADDR_FIXED, slave_id}) else $error("foreign address acked");
  read_dir_a: assert property (state == ST_ACK_ADDR && scl_fall
    && !bus_start && !bus_stop |=> state == (sh[0] ? ST_TX : ST_RX))
    else $error("direction bit misread");
  ptr_step_a: assert property (state == ST_RX && have_ptr && scl_rise
    && cnt == LAST_BIT && !ptr[8] && !bus_start && !bus_stop
    |=> ptr == $past(ptr) + 9'h001) else $error("pointer did not step");
  write_window_a: assert property (mem_we |-> !ovf
    && (first || ptr[7:0] <= WR_TOP)) else $error("write past the window");
  read_only_a: assert property (mem_we |-> !RO_MAP[ptr[7:0]])
    else $error("read-only location written");
  function_command_byte_direct_a: assert property (mem_we && ptr[7:0] == FUNCTION_COMMAND_BYTE_LOC
    |-> first ##1 function_command_byte_stb_o) else $error("function command via increment");
  stop_idle_a: assert property (bus_stop |=> state == ST_IDLE
    && !sda_oe_o) else $error("stop did not release the bus");
  past_top_a: assert property (state == ST_ACK_TX && scl_fall && mack
    && ptr[8] && !bus_start && !bus_stop |=> tx == READ_PAST)
    else $error("read past top not all ones");
  nack_release_a: assert property (state == ST_ACK_TX && scl_fall
    && !mack |=> !sda_oe_o [*2]) else $error("sda held after master nack");
  tx_drive_a: assert property (state == ST_TX && $stable(state)
    |-> sda_oe_o == !tx[7]) else $error("sda not following transmit bit");

endmodule

// ===== dv/twowire_master_model.sv
// behavioural two-wire bus master that drives scl and pulls sda low
// assumes a pull-up on sda; sda_i is the resolved wire level
module twowire_master_model (
  input  wire logic sda_i,    // resolved sda level
  output logic      scl_o,    // serial clock to the slave
  output logic      sda_oe_o  // high while pulling sda low
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // bit timing: 800 ns period, quarters of 200 ns
  // ---------------------------------------------------------------
  localparam int QTR = 200;

  // bus idle: both lines high
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  // start or repeated start: sda falls while scl high
  task automatic start();
    sda_oe_o = 1'b0;
    #QTR scl_o = 1'b1;
    #(2*QTR) sda_oe_o = 1'b1;
    #(2*QTR) scl_o = 1'b0;
    #QTR;
  endtask

  // stop: sda rises while scl high, bus left idle
  task automatic stop();
    sda_oe_o = 1'b1;
    #QTR scl_o = 1'b1;
    #(2*QTR) sda_oe_o = 1'b0;
    #(2*QTR);
  endtask

  // master owns sda for the whole bit, changed only while scl low
  task automatic put_bit(input logic b);
    sda_oe_o = ~b;
    #QTR scl_o = 1'b1;
    #(2*QTR) scl_o = 1'b0;
    #QTR;
  endtask

  // released sda, sampled mid high phase
  task automatic get_bit(output logic b);
    sda_oe_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR b = sda_i;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask

  // one byte out, msb first, then the slave's acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    ack = ~a;
  endtask

  // one byte in; nack on the last wanted byte ends the read
  task automatic recv(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
endmodule

// ===== dv/test_twowire_register_access_slave.sv
// self-checking bench for the two-wire register slave
// assumes the master model owns scl; sda has a pull-up
module test_twowire_register_access_slave
  import twowire_slave_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // signals and tables
  // ---------------------------------------------------------------
  typedef struct {
    logic [7:0] ptr;
    int         n;
    logic [7:0] st;
    logic [7:0] last;
  } row_s;
  logic       sys_clk_i  = 1'b0;
  logic       rst_n_i    = 1'b0;
  logic       scl;
  wire  logic sda;
  logic       m_oe;
  logic       sda_o;
  logic       sda_oe_o;
  logic       wr_stb_o;
  logic       function_command_byte_stb_o;
  logic       busy_o;
  logic       ack;
  logic [3:0] slave_id_o;
  logic [7:0] wr_addr_o;
  logic [7:0] wr_data_o;
  logic [7:0] function_command_byte_data_o;
  logic [7:0] last_a;
  logic [7:0] last_d;
  logic [7:0] got [4];
  int         fail_count = 0;
  int         checked    = 0;
  int         wr_n       = 0;
  int         fc_n       = 0;
  int         w0;
  int         f0;
  // location 20h read-only, so an auto-inc run must skip it
  row_s       rows [4] = '{'{8'h10, 3, 8'h03, 8'h12},
                           '{8'h4E, 3, 8'h02, 8'h4F},
                           '{8'h1F, 3, 8'h02, 8'h21},
                           '{8'hFD, 2, 8'h01, 8'hFD}};
  logic [7:0] bad_addr [3] = '{8'h4C, 8'h6E, 8'hEC};

  // open drain wire: anyone pulling low wins
  assign sda = (sda_oe_o ? sda_o : 1'b1) & ~m_oe;

  // 10 MHz system clock
  always #50 sys_clk_i = ~sys_clk_i;

  twowire_register_access_slave #(.RO_MAP(256'h1 << 32)) u_dut (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .scl_i      (scl),
    .sda_i      (sda),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o),
    .slave_id_o (slave_id_o),
    .wr_stb_o   (wr_stb_o),
    .wr_addr_o  (wr_addr_o),
    .wr_data_o  (wr_data_o),
    .function_command_byte_stb_o (function_command_byte_stb_o),
    .function_command_byte_data_o(function_command_byte_data_o),
    .busy_o     (busy_o)
  );

  twowire_master_model u_mst (
    .sda_i   (sda),
    .scl_o   (scl),
    .sda_oe_o(m_oe)
  );

  // count stores; strobes last one cycle, so sample every edge
  always @(posedge sys_clk_i) begin
    if (wr_stb_o === 1'b1) begin
      wr_n++;
      last_a = wr_addr_o;
      last_d = wr_data_o;
    end
    if (function_command_byte_stb_o === 1'b1) fc_n++;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // lines stay idle high through reset so the sync flops fill clean
  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #10;
  endtask

  // data written to location a is always a ^ 5Ah
  task automatic wr_txn(input logic [7:0] aw, input logic [7:0] ptr,
                        input int n);
    logic a;
    u_mst.start();
    u_mst.send(aw, a);
    chk("addr_ack", 8'h1, {7'h0, a});
    u_mst.send(ptr, a);
    chk("ptr_ack", 8'h1, {7'h0, a});
    for (int i = 0; i < n; i++) begin
      u_mst.send((ptr + 8'(i)) ^ 8'h5A, a);
      chk("data_ack", 8'h1, {7'h0, a});
    end
    u_mst.stop();
  endtask

  task automatic rd(input logic [7:0] aw, input logic [7:0] ptr,
                    input int n);
    logic a;
    u_mst.start();
    u_mst.send(aw, a);
    u_mst.send(ptr, a);
    u_mst.start();
    u_mst.send(aw | 8'h01, a);
    chk("rd_ack", 8'h1, {7'h0, a});
    for (int i = 0; i < n; i++) u_mst.recv(i == n - 1, got[i]);
    u_mst.stop();
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    chk("id_rst", {4'h0, SLAVE_ID_RST}, {4'h0, slave_id_o});
    chk("oe_rst", 8'h0, {7'h0, sda_oe_o});
    foreach (rows[r]) begin
      w0 = wr_n;
      f0 = fc_n;
      wr_txn(8'h6C, rows[r].ptr, rows[r].n);
      chk("stores", rows[r].st, 8'(wr_n - w0));
      chk("last_addr", rows[r].last, last_a);
      chk("last_data", rows[r].last ^ 8'h5A, last_d);
      chk("no_function_command_byte", 8'h0, 8'(fc_n - f0));
    end
    // wrong fixed bits or wrong id: no acknowledge, slave idle
    foreach (bad_addr[i]) begin
      u_mst.start();
      u_mst.send(bad_addr[i], ack);
      chk("bad_ack", 8'h0, {7'h0, ack});
      u_mst.stop();
      chk("bad_busy", 8'h0, {7'h0, busy_o});
    end
    rd(8'h6C, 8'h10, 3);
    for (int i = 0; i < 3; i++) begin
      chk("rd_data", (8'h10 + 8'(i)) ^ 8'h5A, got[i]);
    end
    chk("rd_oe", 8'h0, {7'h0, sda_oe_o});
    chk("rd_busy", 8'h0, {7'h0, busy_o});
    // got[0] is a reserved location and is left unchecked
    rd(8'h6C, 8'hFF, 3);
    chk("past_1", READ_PAST, got[1]);
    chk("past_2", READ_PAST, got[2]);
    f0 = fc_n;
    wr_txn(8'h6C, 8'hFE, 1);
    chk("function_command_byte_n", 8'h1, 8'(fc_n - f0));
    chk("function_command_byte_data", 8'hA4, function_command_byte_data_o);
    // byte cut by stop after four bits never lands
    w0 = wr_n;
    u_mst.start();
    u_mst.send(8'h6C, ack);
    u_mst.send(8'h40, ack);
    repeat (4) u_mst.put_bit(1'b1);
    // mid-byte the slave must still count itself addressed
    chk("short_on", 8'h1, {7'h0, busy_o});
    u_mst.stop();
    chk("short", 8'h0, 8'(wr_n - w0));
    chk("short_busy", 8'h0, {7'h0, busy_o});
    // 7Dh gets 27h: id bits become 2, address byte 64h
    wr_txn(8'h6C, 8'h7D, 1);
    chk("id_new", 8'h2, {4'h0, slave_id_o});
    u_mst.start();
    u_mst.send(8'h6C, ack);
    chk("old_id", 8'h0, {7'h0, ack});
    u_mst.stop();
    rd(8'h64, 8'h7D, 1);
    chk("id_read", 8'h20, got[0]);
    // second reset is launched on a clock edge; the bus lines change 10 ns after an edge
    @(posedge sys_clk_i);
    do_reset();
    chk("id_rst2", {4'h0, SLAVE_ID_RST}, {4'h0, slave_id_o});
    test_done();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    fail_count++;
    test_done();
  end
endmodule
